// ==== rtl/comparator_event_pkg.sv ====
package comparator_event_pkg;

   // ---------------------------------------------------------------
   // Register byte addresses
   // ---------------------------------------------------------------
   localparam logic [7:0] CTRL_ADDR = 8'h00;
   localparam logic [7:0] MASKSRC_ADDR = 8'h04;
   localparam logic [7:0] SHARED_STAT_ADDR = 8'h08;
   localparam logic [7:0] IRQ_STAT_ADDR = 8'h0c;
   localparam logic [7:0] IRQ_MASK_ADDR = 8'h10;

   // ---------------------------------------------------------------
   // Control register fields
   // ---------------------------------------------------------------
   localparam int ENABLE_BIT = 15;
   localparam int PIN_OE_BIT = 14;
   localparam int INVERT_BIT = 13;
   localparam int EVENT_FLAG_BIT = 9;
   localparam int RESULT_BIT = 8;
   localparam int EDGE_SEL_LSB = 6;
   localparam int REF_SEL_BIT = 4;
   localparam int CHAN_SEL_LSB = 0;
   localparam logic [15:0] CTRL_RESET = 16'h0000;

   // ---------------------------------------------------------------
   // Mask source fields
   // ---------------------------------------------------------------
   localparam int MASK_A_LSB = 0;
   localparam int MASK_B_LSB = 4;
   localparam int MASK_C_LSB = 8;
   localparam logic [15:0] MASKSRC_WRITABLE = 16'h0fff;
   localparam logic [15:0] MASKSRC_RESET = 16'h0000;
   localparam logic [3:0] SRC_FAULT_TWO = 4'he;
   localparam logic [3:0] SRC_FAULT_FOUR = 4'hf;
   localparam logic [3:0] SRC_PWM_LAST = 4'h5;

   // ---------------------------------------------------------------
   // Shared status positions of this comparator
   // ---------------------------------------------------------------
   localparam int SHARED_EVENT_BIT = 11;
   localparam int SHARED_RESULT_BIT = 3;

   // Interrupt status/mask: bit 0 is the comparator event
   localparam int IRQ_EVENT_BIT = 0;
   localparam logic IRQ_MASK_RESET = 1'b0;

   // AXI responses
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   // Edge selection modes
   typedef enum logic [1:0] {
      EDGE_NONE = 2'b00,
      EDGE_RISE = 2'b01,
      EDGE_FALL = 2'b10,
      EDGE_ANY = 2'b11
   } edge_mode_t;

endpackage

// ==== rtl/comparator_event_and_mask_select.sv ====
`timescale 1ns/1ps
`default_nettype none

module comparator_event_and_mask_select
   import comparator_event_pkg::*;
#(
   parameter logic [3:0] MINUS_PRESENT = 4'hf,
   parameter logic PLUS_PIN_PRESENT = 1'b1
) (
   input wire logic ref_clk,
   input wire logic rst,
   // AXI4-Lite slave
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Analog comparator side
   input wire logic compareRaw,
   output logic comparatorEnable,
   output logic plusInputReferenceSelect,
   output logic plusInputGroundTie,
   output logic [1:0] minusInputChannelSelect,
   output logic minusInputGroundTie,
   // Output pin
   output logic comparatorFourOutputPin,
   output logic comparatorFourOutputPinOe,
   // Event outputs
   output logic comparatorTrigger,
   output logic comparatorEvent,
   output logic irq,
   // Blanking sources
   input wire logic pwmGen1Low,
   input wire logic pwmGen1High,
   input wire logic pwmGen2Low,
   input wire logic pwmGen2High,
   input wire logic pwmGen3Low,
   input wire logic pwmGen3High,
   input wire logic faultInputTwo,
   input wire logic faultInputFour,
   output logic maskA,
   output logic maskB,
   output logic maskC
);

   // ---------------------------------------------------------------
   // Register state
   // ---------------------------------------------------------------
   logic enableBit;
   logic pinOeBit;
   logic invertBit;
   logic stickyEventFlag;
   logic resultStatus;
   edge_mode_t edgeMode;
   logic refSelBit;
   logic [1:0] chanSel;
   logic [15:0] maskSourceSelect;
   logic [15:0] ctrlRead;
   logic irqStatus;
   logic irqMask;

   // ---------------------------------------------------------------
   // AXI write channel state
   // ---------------------------------------------------------------
   logic awHeld;
   logic wHeld;
   logic [7:0] awAddr;
   logic [31:0] wData;
   logic [3:0] wStrb;
   logic bValid;
   logic [1:0] bResp;

   // Address and data are caught separately, in either order
   assign s_axi_awready = !awHeld && !bValid;
   assign s_axi_wready = !wHeld && !bValid;
   assign s_axi_bvalid = bValid;
   assign s_axi_bresp = bResp;

   wire awTake = s_axi_awvalid && s_axi_awready;
   wire wTake = s_axi_wvalid && s_axi_wready;
   wire doWrite = awHeld && wHeld && !bValid;

   // Write decode; only the low two byte lanes hold register bits
   wire wrCtrl = doWrite && (awAddr == CTRL_ADDR);
   wire wrMaskSrc = doWrite && (awAddr == MASKSRC_ADDR);
   wire wrIrqStat = doWrite && (awAddr == IRQ_STAT_ADDR);
   wire wrIrqMask = doWrite && (awAddr == IRQ_MASK_ADDR);
   wire wrShared = doWrite && (awAddr == SHARED_STAT_ADDR);
   wire wrHit = wrCtrl || wrMaskSrc || wrIrqStat || wrIrqMask || wrShared;
   wire [15:0] laneMask = {{8{wStrb[1]}}, {8{wStrb[0]}}};
   wire [15:0] ctrlOld = ctrlRead;
   wire [15:0] ctrlNew = (wData[15:0] & laneMask) | (ctrlOld & ~laneMask);
   wire [15:0] maskSrcNew =
      ((wData[15:0] & laneMask) | (maskSourceSelect & ~laneMask)) & MASKSRC_WRITABLE;

   // Address/data holding and write response
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         awHeld <= 1'b0;
         wHeld <= 1'b0;
         awAddr <= 8'h00;
         wData <= 32'h0000_0000;
         wStrb <= 4'h0;
         bValid <= 1'b0;
         bResp <= RESP_OKAY;
      end else begin
         if (awTake) begin
            awHeld <= 1'b1;
            awAddr <= {s_axi_awaddr[7:2], 2'b00};
         end
         if (wTake) begin
            wHeld <= 1'b1;
            wData <= s_axi_wdata;
            wStrb <= s_axi_wstrb;
         end
         if (doWrite) begin
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            bValid <= 1'b1;
            bResp <= wrHit ? RESP_OKAY : RESP_SLVERR;
         end else if (bValid && s_axi_bready) begin
            bValid <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // Comparator result path
   // ---------------------------------------------------------------
   logic syncFirst;
   logic syncSecond;
   logic rawPrev;

   // Two-flop synchroniser; only syncSecond feeds any logic
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         syncFirst <= 1'b0;
         syncSecond <= 1'b0;
         rawPrev <= 1'b0;
      end else begin
         syncFirst <= compareRaw;
         syncSecond <= syncFirst;
         rawPrev <= syncSecond;
      end
   end

   // Edges are taken on the raw sample, so toggling the inversion bit
   // does not itself look like a comparator transition.
   wire rawRise = syncSecond && !rawPrev;
   wire rawFall = !syncSecond && rawPrev;
   wire adjRise = invertBit ? rawFall : rawRise;
   wire adjFall = invertBit ? rawRise : rawFall;
   wire adjResult = syncSecond ^ invertBit;

   // Edge qualification per mode
   logic edgeHit;
   always_comb begin
      case (edgeMode)
         EDGE_ANY: edgeHit = rawRise || rawFall;
         EDGE_FALL: edgeHit = adjFall;
         EDGE_RISE: edgeHit = adjRise;
         EDGE_NONE: edgeHit = 1'b0;
         default: edgeHit = 1'b0;
      endcase
   end

   // An event needs the comparator on and the sticky flag clear
   wire fire = edgeHit && enableBit && !stickyEventFlag;

   // Software clears the flag by writing zero; a new event wins
   wire flagClear = wrCtrl && wStrb[1] && !wData[EVENT_FLAG_BIT];
   wire irqClear = wrIrqStat && wStrb[0] && wData[IRQ_EVENT_BIT];

   // ---------------------------------------------------------------
   // Control register, sticky flag and event outputs
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         enableBit <= CTRL_RESET[ENABLE_BIT];
         pinOeBit <= CTRL_RESET[PIN_OE_BIT];
         invertBit <= CTRL_RESET[INVERT_BIT];
         edgeMode <= edge_mode_t'(CTRL_RESET[EDGE_SEL_LSB +: 2]);
         refSelBit <= CTRL_RESET[REF_SEL_BIT];
         chanSel <= CTRL_RESET[CHAN_SEL_LSB +: 2];
         stickyEventFlag <= CTRL_RESET[EVENT_FLAG_BIT];
         resultStatus <= CTRL_RESET[RESULT_BIT];
         comparatorTrigger <= 1'b0;
         comparatorEvent <= 1'b0;
      end else begin
         if (wrCtrl) begin
            enableBit <= ctrlNew[ENABLE_BIT];
            pinOeBit <= ctrlNew[PIN_OE_BIT];
            invertBit <= ctrlNew[INVERT_BIT];
            edgeMode <= edge_mode_t'(ctrlNew[EDGE_SEL_LSB +: 2]);
            refSelBit <= ctrlNew[REF_SEL_BIT];
            chanSel <= ctrlNew[CHAN_SEL_LSB +: 2];
         end
         if (fire)
            stickyEventFlag <= 1'b1;
         else if (flagClear)
            stickyEventFlag <= 1'b0;
         // Status reads zero while off, the inverted sense when inverting
         resultStatus <= enableBit && adjResult;
         comparatorTrigger <= fire;
         comparatorEvent <= fire;
      end
   end

   // ---------------------------------------------------------------
   // Interrupt status and mask
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         irqStatus <= 1'b0;
         irqMask <= IRQ_MASK_RESET;
      end else begin
         if (fire)
            irqStatus <= 1'b1;
         else if (irqClear)
            irqStatus <= 1'b0;
         if (wrIrqMask && wStrb[0])
            irqMask <= wData[IRQ_EVENT_BIT];
      end
   end

   assign irq = irqStatus && irqMask;

   // ---------------------------------------------------------------
   // Output pin
   // ---------------------------------------------------------------
   // Registered so the pin never glitches on mux changes
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         comparatorFourOutputPin <= 1'b0;
         comparatorFourOutputPinOe <= 1'b0;
      end else begin
         comparatorFourOutputPin <= enableBit && adjResult;
         comparatorFourOutputPinOe <= pinOeBit;
      end
   end

   // ---------------------------------------------------------------
   // Analog input selection
   // ---------------------------------------------------------------
   assign comparatorEnable = enableBit;
   assign plusInputReferenceSelect = refSelBit;
   assign minusInputChannelSelect = chanSel;
   // Absent inputs are grounded rather than left floating
   assign plusInputGroundTie = !refSelBit && !PLUS_PIN_PRESENT;
   assign minusInputGroundTie = !MINUS_PRESENT[chanSel];

   // ---------------------------------------------------------------
   // Mask source selection
   // ---------------------------------------------------------------
   logic [2:0] maskPick;
   wire [7:0] sourceBus = {faultInputFour, faultInputTwo, pwmGen3High, pwmGen3Low,
                           pwmGen2High, pwmGen2Low, pwmGen1High, pwmGen1Low};
   localparam int MASK_LSB [3] = '{MASK_A_LSB, MASK_B_LSB, MASK_C_LSB};

   // Reserved codes blank nothing: the source reads as zero
   genvar g;
   generate
      for (g = 0; g < 3; g = g + 1) begin : gMask
         wire [3:0] code = maskSourceSelect[MASK_LSB[g] +: 4];
         wire isPwm = code <= SRC_PWM_LAST;
         wire [2:0] idx = isPwm ? code[2:0] :
                          (code == SRC_FAULT_TWO) ? 3'h6 : 3'h7;
         wire valid = isPwm || (code == SRC_FAULT_TWO) || (code == SRC_FAULT_FOUR);
         always_ff @(posedge ref_clk) begin
            if (rst)
               maskPick[g] <= 1'b0;
            else
               maskPick[g] <= valid && sourceBus[idx];
         end
      end
   endgenerate

   assign maskA = maskPick[0];
   assign maskB = maskPick[1];
   assign maskC = maskPick[2];

   // Mask source register; unimplemented top nibble stays zero
   always_ff @(posedge ref_clk) begin
      if (rst)
         maskSourceSelect <= MASKSRC_RESET;
      else if (wrMaskSrc)
         maskSourceSelect <= maskSrcNew;
   end

   // ---------------------------------------------------------------
   // Read path
   // ---------------------------------------------------------------
   logic rValid;
   logic [31:0] rData;
   logic [1:0] rResp;
   logic [15:0] sharedRead;

   // Control register image, reserved bits zero
   always_comb begin
      ctrlRead = 16'h0000;
      ctrlRead[ENABLE_BIT] = enableBit;
      ctrlRead[PIN_OE_BIT] = pinOeBit;
      ctrlRead[INVERT_BIT] = invertBit;
      ctrlRead[EVENT_FLAG_BIT] = stickyEventFlag;
      ctrlRead[RESULT_BIT] = resultStatus;
      ctrlRead[EDGE_SEL_LSB +: 2] = edgeMode;
      ctrlRead[REF_SEL_BIT] = refSelBit;
      ctrlRead[CHAN_SEL_LSB +: 2] = chanSel;
   end

   // Shared status mirrors this comparator's flag and result
   always_comb begin
      sharedRead = 16'h0000;
      sharedRead[SHARED_EVENT_BIT] = stickyEventFlag;
      sharedRead[SHARED_RESULT_BIT] = resultStatus;
   end

   wire [7:0] rdAddr = {s_axi_araddr[7:2], 2'b00};
   wire rdCtrl = rdAddr == CTRL_ADDR;
   wire rdMaskSrc = rdAddr == MASKSRC_ADDR;
   wire rdShared = rdAddr == SHARED_STAT_ADDR;
   wire rdIrqStat = rdAddr == IRQ_STAT_ADDR;
   wire rdIrqMask = rdAddr == IRQ_MASK_ADDR;
   wire rdHit = rdCtrl || rdMaskSrc || rdShared || rdIrqStat || rdIrqMask;
   wire [15:0] rdWord = rdCtrl ? ctrlRead :
                        rdMaskSrc ? maskSourceSelect :
                        rdShared ? sharedRead :
                        rdIrqStat ? {15'h0000, irqStatus} :
                        rdIrqMask ? {15'h0000, irqMask} : 16'h0000;

   assign s_axi_arready = !rValid;
   assign s_axi_rvalid = rValid;
   assign s_axi_rdata = rData;
   assign s_axi_rresp = rResp;

   // One read in flight; data captured at the address handshake
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rValid <= 1'b0;
         rData <= 32'h0000_0000;
         rResp <= RESP_OKAY;
      end else if (s_axi_arvalid && !rValid) begin
         rValid <= 1'b1;
         rData <= {16'h0000, rdWord};
         rResp <= rdHit ? RESP_OKAY : RESP_SLVERR;
      end else if (rValid && s_axi_rready) begin
         rValid <= 1'b0;
      end
   end

endmodule // comparator_event_and_mask_select

`default_nettype wire

// ==== verif/comparator_event_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
// --------------------
// Port checker
// --------------------
module comparator_event_chk #(
   parameter logic [3:0] MINUS_PRESENT = 4'hf,
   parameter logic PLUS_PIN_PRESENT = 1'b1
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic compareRaw,
   input wire logic comparatorEnable,
   input wire logic plusInputReferenceSelect,
   input wire logic plusInputGroundTie,
   input wire logic [1:0] minusInputChannelSelect,
   input wire logic minusInputGroundTie,
   input wire logic comparatorFourOutputPin,
   input wire logic comparatorTrigger,
   input wire logic comparatorEvent
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   // Pulses leave together; the flag set with them blocks an immediate repeat
   a_pulse_pair: assert property (comparatorTrigger == comparatorEvent)
      else $error("trigger and event differ");
   a_single_pulse: assert property (comparatorTrigger |=> !comparatorTrigger)
      else $error("trigger repeated");
   // Two sync flops and the pulse register: cause lies three samples back
   a_edge_cause: assert property (comparatorTrigger && !$past(rst, 4)
      |-> $past(compareRaw, 3) != $past(compareRaw, 4)) else $error("trigger without edge");
   a_off_no_event: assert property (!$past(comparatorEnable) |-> !comparatorTrigger)
      else $error("event while disabled");
   a_off_pin_low: assert property (!$past(comparatorEnable) |-> !comparatorFourOutputPin)
      else $error("pin high while disabled");
   a_minus_tie: assert property (minusInputGroundTie ==
      !MINUS_PRESENT[minusInputChannelSelect]) else $error("minus tie wrong");
   a_plus_tie: assert property (plusInputGroundTie ==
      (!plusInputReferenceSelect && !PLUS_PIN_PRESENT)) else $error("plus tie wrong");
   // Bus answers stand until taken
   a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
   a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
   a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while busy");
endmodule // comparator_event_chk

bind comparator_event_and_mask_select comparator_event_chk #(
   .MINUS_PRESENT(MINUS_PRESENT), .PLUS_PIN_PRESENT(PLUS_PIN_PRESENT)) i_chk (
   .ref_clk, .rst, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arready,
   .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .compareRaw, .comparatorEnable,
   .plusInputReferenceSelect, .plusInputGroundTie, .minusInputChannelSelect,
   .minusInputGroundTie, .comparatorFourOutputPin, .comparatorTrigger, .comparatorEvent);
`default_nettype wire

// ==== verif/comparator_source_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// --------------------
// Analog inputs and blanking sources
// --------------------
module comparator_source_model (
   input wire logic ref_clk,
   input wire logic refSel,
   input wire logic plusTie,
   input wire logic [1:0] chan,
   input wire logic minusTie,
   output logic compareRaw,
   output logic [7:0] srcLines
);
   int vref = 5;
   int vplus = 0;
   int vm[4] = '{4, 2, 6, 7};
   int plusV;
   int minusV;
   // Routing as the selects and ground ties command
   always_comb begin
      plusV = refSel ? vref : (plusTie ? 0 : vplus);
      minusV = minusTie ? 0 : vm[chan];
   end
   // Settles off the clock grid, like a real comparator
   assign #3 compareRaw = plusV > minusV;
   initial srcLines = 8'h00;
   // Sources move only just after a rising edge
   task automatic setSources(input logic [7:0] p);
      @(posedge ref_clk);
      srcLines <= p;
   endtask
endmodule // comparator_source_model
`default_nettype wire

// ==== verif/comparator_event_and_mask_select_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin nTests++; if ((a) !== (b)) begin nFail++; \
   $display("[ERR] %0t got %h want %h", $time, a, b); end end
// --------------------
// Bench
// --------------------
module comparator_event_and_mask_select_bench
   import comparator_event_pkg::*;
();
   localparam logic [3:0] MINUS_P = 4'h7;
   localparam logic PLUS_P = 1'b0;
   logic ref_clk = 1'b0, rst = 1'b1;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, pat;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, ctl;
   logic [3:0] s_axi_wstrb = 4'h3;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, inv, fire;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, minusInputChannelSelect;
   logic compareRaw, comparatorEnable, plusInputReferenceSelect, plusInputGroundTie;
   logic minusInputGroundTie, comparatorFourOutputPin, comparatorFourOutputPinOe;
   logic comparatorTrigger, comparatorEvent, irq, maskA, maskB, maskC;
   logic [7:0] srcLines;
   logic [33:0] notes[$], note;
   logic [7:0] regAddr[5] = '{CTRL_ADDR, MASKSRC_ADDR, SHARED_STAT_ADDR, IRQ_STAT_ADDR,
      IRQ_MASK_ADDR};
   int nFail = 0, nTests = 0, nTrig = 0;
   integer seed = 32'h95c215eb;

   comparator_event_and_mask_select #(.MINUS_PRESENT(MINUS_P), .PLUS_PIN_PRESENT(PLUS_P)) i_dut (
      .ref_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .compareRaw, .comparatorEnable,
      .plusInputReferenceSelect, .plusInputGroundTie, .minusInputChannelSelect,
      .minusInputGroundTie, .comparatorFourOutputPin, .comparatorFourOutputPinOe,
      .comparatorTrigger, .comparatorEvent, .irq, .pwmGen1Low(srcLines[0]),
      .pwmGen1High(srcLines[1]), .pwmGen2Low(srcLines[2]), .pwmGen2High(srcLines[3]),
      .pwmGen3Low(srcLines[4]), .pwmGen3High(srcLines[5]), .faultInputTwo(srcLines[6]),
      .faultInputFour(srcLines[7]), .maskA, .maskB, .maskC);
   comparator_source_model i_src (.ref_clk, .refSel(plusInputReferenceSelect),
      .plusTie(plusInputGroundTie), .chan(minusInputChannelSelect),
      .minusTie(minusInputGroundTie), .compareRaw, .srcLines);

   always #25 ref_clk = ~ref_clk;

   // Expected blanking level for a source code; reserved codes give 0
   function automatic logic srcBit(input logic [3:0] code, input logic [7:0] p);
      if (code <= 4'h5) return p[code];
      if (code == 4'he) return p[6];
      if (code == 4'hf) return p[7];
      return 1'b0;
   endfunction

   // Ready is looked at on the falling edge, so the decision is settled
   task automatic axiWrite(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      logic hitA, hitW, hitB;
      @(posedge ref_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      hitB = 1'b0;
      while (!hitB) begin
         @(negedge ref_clk);
         hitA = s_axi_awvalid && s_axi_awready;
         hitW = s_axi_wvalid && s_axi_wready;
         hitB = s_axi_bvalid;
         if (hitB) `CHK(s_axi_bresp, r)
         @(posedge ref_clk);
         if (hitA) s_axi_awvalid <= 1'b0;
         if (hitW) s_axi_wvalid <= 1'b0;
      end
      s_axi_bready <= 1'b0;
   endtask

   task automatic axiRead(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      logic hitA, hitR;
      @(posedge ref_clk);
      notes.push_back({r, d});
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      hitR = 1'b0;
      while (!hitR) begin
         @(negedge ref_clk);
         hitA = s_axi_arvalid && s_axi_arready;
         hitR = s_axi_rvalid;
         @(posedge ref_clk);
         if (hitA) s_axi_arvalid <= 1'b0;
      end
      s_axi_rready <= 1'b0;
   endtask

   // Read answers meet the oldest note; trigger pulses are tallied
   always @(negedge ref_clk) begin
      if (s_axi_rvalid && s_axi_rready) begin
         note = notes.pop_front();
         `CHK({s_axi_rresp, s_axi_rdata}, note)
      end
      if (comparatorTrigger) nTrig++;
   end

   task automatic closeOut();
      $display("Comparisons %0d, mismatches %0d", nTests, nFail);
      if (nFail == 0 && nTests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // Cut a hang short
   initial begin
      repeat (20000) @(posedge ref_clk);
      nFail++;
      closeOut();
   end

   initial begin
      repeat (10) @(posedge ref_clk);
      rst <= 1'b0;
      for (int i = 0; i < 5; i++) axiRead(regAddr[i], 32'h0, RESP_OKAY);
      axiWrite(MASKSRC_ADDR, 32'hffffffff, RESP_OKAY);
      axiRead(MASKSRC_ADDR, 32'h00000fff, RESP_OKAY);
      axiWrite(8'h14, 32'hffffffff, RESP_SLVERR);
      axiRead(8'h14, 32'h0, RESP_SLVERR);
      // Every code on A, its neighbours on B and C, random source levels
      for (int c = 0; c < 16; c++) begin
         pat = 8'($random(seed));
         i_src.setSources(pat);
         axiWrite(MASKSRC_ADDR, {20'h0, 4'(c + 2), 4'(c + 1), 4'(c)}, RESP_OKAY);
         repeat (3) @(posedge ref_clk);
         @(negedge ref_clk);
         `CHK(maskA, srcBit(4'(c), pat))
         `CHK(maskB, srcBit(4'(c + 1), pat))
         `CHK(maskC, srcBit(4'(c + 2), pat))
      end
      // Each edge mode, plain and inverted; interrupt unmasked when inverted
      for (int m = 0; m < 4; m++) begin
         for (int v = 0; v < 2; v++) begin
            inv = v[0];
            ctl = 32'h0000c010 | (32'(v) << 13) | (32'(m) << 6);
            i_src.vref <= 0;
            axiWrite(IRQ_MASK_ADDR, 32'(v), RESP_OKAY);
            axiWrite(CTRL_ADDR, ctl, RESP_OKAY);
            axiWrite(IRQ_STAT_ADDR, 32'h1, RESP_OKAY);
            nTrig = 0;
            i_src.vref <= 8;
            repeat (6) @(posedge ref_clk);
            fire = (m == 3) || (m == (inv ? 2 : 1));
            @(negedge ref_clk);
            `CHK(nTrig, int'(fire))
            `CHK(irq, fire && inv)
            `CHK(comparatorFourOutputPin, ~inv)
            `CHK(comparatorFourOutputPinOe, 1'b1)
            axiRead(SHARED_STAT_ADDR, 32'({fire, 7'h0, ~inv, 3'h0}), RESP_OKAY);
            axiRead(CTRL_ADDR, ctl | (32'({fire, ~inv}) << 8), RESP_OKAY);
            // A set flag holds off the falling edge
            nTrig = 0;
            i_src.vref <= 0;
            repeat (6) @(posedge ref_clk);
            `CHK(nTrig, int'(!fire && (m == 3 || m == (inv ? 1 : 2))))
            axiWrite(IRQ_STAT_ADDR, 32'h1, RESP_OKAY);
            @(negedge ref_clk);
            `CHK(irq, 1'b0)
         end
      end
      // Disabled: no events in any-change mode, pin low
      axiWrite(CTRL_ADDR, 32'h000000d0, RESP_OKAY);
      nTrig = 0;
      i_src.vref <= 8;
      repeat (6) @(posedge ref_clk);
      i_src.vref <= 0;
      repeat (6) @(posedge ref_clk);
      `CHK(nTrig, 0)
      // Plus and minus routing; absent plus pin and fourth minus input read as ground
      i_src.vplus <= 3;
      i_src.vref <= 5;
      for (int r = 0; r < 2; r++) begin
         for (int c = 0; c < 4; c++) begin
            axiWrite(CTRL_ADDR, 32'h00008000 | (32'(r) << 4) | 32'(c), RESP_OKAY);
            repeat (5) @(posedge ref_clk);
            fire = (r ? i_src.vref : (PLUS_P ? 3 : 0)) > (MINUS_P[c] ? i_src.vm[c] : 0);
            axiRead(SHARED_STAT_ADDR, 32'({fire, 3'h0}), RESP_OKAY);
         end
      end
      closeOut();
   end
endmodule // comparator_event_and_mask_select_bench
`default_nettype wire
